//--- design/ocs_pkg.sv
// constants, types and helpers for the output clock and shadow block
package ocs_pkg;

  // register offsets
  localparam logic [7:0] ADDR_OUT_CFG = 8'h0d;
  localparam logic [7:0] ADDR_CLK12   = 8'h0e;
  localparam logic [7:0] ADDR_CLK3    = 8'h0f;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;

  // reset values and writable masks
  localparam logic [15:0] RST_OUT_CFG  = 16'h0007;
  localparam logic [15:0] RST_CLK12    = 16'h0501;
  localparam logic [15:0] RST_CLK3     = 16'h0003;
  localparam logic [15:0] MASK_OUT_CFG = 16'h0fff;
  localparam logic [15:0] MASK_CLK12   = 16'hefef;
  localparam logic [15:0] MASK_CLK3    = 16'h00ef;

  // field positions
  localparam int BIT_SPOOF  = 0;
  localparam int BIT_ADAPT  = 6;
  localparam int BIT_CODES  = 10;
  localparam int BIT_FREEZE = 11;
  localparam int DIV1_LSB   = 0;
  localparam int SLEW1_LSB  = 5;
  localparam int DIV2_LSB   = 8;
  localparam int SLEW2_LSB  = 13;
  localparam int DIV3_LSB   = 0;
  localparam int SLEW3_LSB  = 5;
  localparam int DIV_W      = 4;
  localparam int SLEW_W     = 3;

  // stream markers
  localparam logic [31:0] CODE_SOF = 32'hff0000ab;
  localparam logic [31:0] CODE_EOF = 32'hff0000b6;
  localparam logic [31:0] CODE_SOL = 32'hff0000b0;
  localparam logic [31:0] CODE_EOL = 32'hff0000bd;
  localparam logic [1:0]  IDX_LAST = 2'h3;

  typedef enum logic [1:0] {SRC_ONE, SRC_TWO, SRC_THREE} ocs_src_t;
  typedef enum logic [2:0] {FMT_DATA, FMT_SOF, FMT_SOL, FMT_EOL, FMT_EOF} ocs_fmt_t;

  // byte idx of a marker, first byte first
  function automatic logic [7:0] marker_byte(input logic [31:0] code, input logic [1:0] idx);
    case (idx)
      2'h0:    marker_byte = code[31:24];
      2'h1:    marker_byte = code[23:16];
      2'h2:    marker_byte = code[15:8];
      default: marker_byte = code[7:0];
    endcase
  endfunction : marker_byte

endpackage : ocs_pkg

//--- design/ocs_divider.sv
// master clock divider giving a one-cycle tick per output clock period
`timescale 1ns/10ps
`default_nettype none
module ocs_divider (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // divisor for the next period
  input  wire logic [ocs_pkg::DIV_W-1:0]   div,
  // period end
  output logic                             tick
);

  logic [ocs_pkg::DIV_W-1:0] cnt_q;
  logic [ocs_pkg::DIV_W-1:0] cnt_d;
  logic [ocs_pkg::DIV_W-1:0] eff_q;
  logic [ocs_pkg::DIV_W-1:0] eff_d;

  assign tick = (cnt_q == eff_q - 4'h1);

  always_comb begin
    cnt_d = cnt_q + 4'h1;
    eff_d = eff_q;
    if (tick) begin
      cnt_d = 4'h0;
      eff_d = (div == 4'h0) ? 4'h1 : div;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      eff_q <= 4'h1;
    end else begin
      cnt_q <= cnt_d;
      eff_q <= eff_d;
    end
  end

  a_div_zero_one: assert property (@(posedge clk) disable iff (!resetn)
    (tick && div == 4'h0) |=> (eff_q == 4'h1 && tick)) else $error("zero divisor not treated as one");
  a_div_count_up: assert property (@(posedge clk) disable iff (!resetn)
    (!tick) |=> (cnt_q == $past(cnt_q) + 4'h1)) else $error("divider count skipped");

endmodule : ocs_divider
`default_nettype wire

//--- design/ocs_shadow_reg.sv
// configuration register with a frame shadow copy
`timescale 1ns/10ps
`default_nettype none
module ocs_shadow_reg #(
  parameter int          W    = 16,
  parameter logic [15:0] RST  = 16'h0000,
  parameter logic [15:0] MASK = 16'hffff
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // software write
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  // shadow control
  input  wire logic         load,
  input  wire logic         freeze,
  // values
  output logic [W-1:0]      cfg_q,
  output logic [W-1:0]      shadow_q
);

  logic [W-1:0] cfg_d;
  logic [W-1:0] shadow_d;

  always_comb begin
    cfg_d    = wr_en ? (wdata & MASK[W-1:0]) : cfg_q;
    shadow_d = shadow_q;
    if (load && !freeze) begin
      shadow_d = cfg_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= RST[W-1:0];
      shadow_q <= RST[W-1:0];
    end else begin
      cfg_q    <= cfg_d;
      shadow_q <= shadow_d;
    end
  end

  a_freeze_holds_copy: assert property (@(posedge clk) disable iff (!resetn)
    freeze |=> $stable(shadow_q)) else $error("shadow changed while frozen");
  a_blank_end_load: assert property (@(posedge clk) disable iff (!resetn)
    (load && !freeze) |=> (shadow_q == $past(cfg_q))) else $error("shadow not reloaded");
  c_blocked_load: cover property (@(posedge clk) disable iff (!resetn) load && freeze && cfg_q != shadow_q);

endmodule : ocs_shadow_reg
`default_nettype wire

//--- design/ocs_top.sv
// output stage: register bank with shadows, adaptive output clock, marker insertion
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - With the marker enable on and uncompressed spoofed frames leaving, every frame gets frame and line markers.
// - The frame-start marker is the bytes ff 00 00 ab and the frame-end marker ff 00 00 b6.
// - The line-start marker is the bytes ff 00 00 b0 and the line-end marker ff 00 00 bd.
// - While the hold bit is set, no covered configuration register is copied into its shadow.
// - With the hold bit clear, shadows reload from their registers at the end of input vertical blanking.
// - Output behaviour follows only the shadows, so writes mid-frame do not disturb the current frame.
// - Source one runs at the master clock divided by the four-bit divisor in bits 3:0 of register 0x0e.
// - A divisor of zero acts exactly like a divisor of one.
// - Source two runs at the master clock divided by the four-bit divisor in bits 11:8 of register 0x0e.
// - The output clock moves from source one to source two once buffer fill reaches one half.
// - While source one drives, the slew setting from bits 7:5 of register 0x0e goes to the driver.
// - While source two drives, the slew setting from bits 15:13 of register 0x0e goes to the driver.
// - Fill-driven switching happens only with the adaptive enable bit set, otherwise source one is used.
// - At three quarters fill the clock moves to source three, back to two below half and to one below a quarter.
// - Every output frame starts on source one whatever source ended the previous frame.
module ocs_top #(
  parameter int FIFO_DEPTH = 1024,
  parameter int LW         = $clog2(FIFO_DEPTH + 1)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata,
  // frame timing and buffer state
  input  wire logic          vblank_end,
  input  wire logic          frame_start,
  input  wire logic [LW-1:0] fifo_level,
  // pixel stream in
  input  wire logic          in_valid,
  input  wire logic [7:0]    in_data,
  input  wire logic          in_uncompressed,
  input  wire logic          in_frame_first,
  input  wire logic          in_line_first,
  input  wire logic          in_line_last,
  input  wire logic          in_frame_last,
  output logic               in_ready,
  // pixel stream out
  output logic               pixel_output_clock,
  output logic [7:0]         out_data,
  output logic               out_valid,
  output logic [2:0]         clk_slew,
  output logic [1:0]         clk_source
);

  localparam logic [LW-1:0] TH_QUARTER = LW'(FIFO_DEPTH / 4);
  localparam logic [LW-1:0] TH_HALF    = LW'(FIFO_DEPTH / 2);
  localparam logic [LW-1:0] TH_THREEQ  = LW'((FIFO_DEPTH * 3) / 4);

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  logic [15:0] cfg_out;
  logic [15:0] sh_out;
  logic [15:0] cfg_c12;
  logic [15:0] sh_c12;
  logic [15:0] cfg_c3;
  logic [15:0] sh_c3;
  logic        freeze;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  ocs_pkg::ocs_src_t sel_q;
  ocs_pkg::ocs_src_t sel_d;

  assign freeze = cfg_out[ocs_pkg::BIT_FREEZE];

  ocs_shadow_reg #(.W(16), .RST(ocs_pkg::RST_OUT_CFG), .MASK(ocs_pkg::MASK_OUT_CFG)) u_out_cfg (
    .clk (clk), .resetn (resetn), .load (vblank_end), .freeze (freeze),
    .wr_en (reg_wr && reg_addr == ocs_pkg::ADDR_OUT_CFG), .wdata (reg_wdata),
    .cfg_q (cfg_out), .shadow_q (sh_out)
  );
  ocs_shadow_reg #(.W(16), .RST(ocs_pkg::RST_CLK12), .MASK(ocs_pkg::MASK_CLK12)) u_clk12 (
    .clk (clk), .resetn (resetn), .load (vblank_end), .freeze (freeze),
    .wr_en (reg_wr && reg_addr == ocs_pkg::ADDR_CLK12), .wdata (reg_wdata),
    .cfg_q (cfg_c12), .shadow_q (sh_c12)
  );
  ocs_shadow_reg #(.W(16), .RST(ocs_pkg::RST_CLK3), .MASK(ocs_pkg::MASK_CLK3)) u_clk3 (
    .clk (clk), .resetn (resetn), .load (vblank_end), .freeze (freeze),
    .wr_en (reg_wr && reg_addr == ocs_pkg::ADDR_CLK3), .wdata (reg_wdata),
    .cfg_q (cfg_c3), .shadow_q (sh_c3)
  );

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd && reg_addr == ocs_pkg::ADDR_OUT_CFG) begin
      rdata_d = cfg_out;
    end else if (reg_rd && reg_addr == ocs_pkg::ADDR_CLK12) begin
      rdata_d = cfg_c12;
    end else if (reg_rd && reg_addr == ocs_pkg::ADDR_CLK3) begin
      rdata_d = cfg_c3;
    end else if (reg_rd && reg_addr == ocs_pkg::ADDR_STATUS) begin
      rdata_d = {13'h0000, freeze, sel_q};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // adaptive output clock

  logic                      tick;
  logic                      adapt;
  logic                      frame_pend_q;
  logic                      frame_pend_d;
  logic [ocs_pkg::DIV_W-1:0] div_next;
  logic [2:0]                slew_q;
  logic [2:0]                slew_d;
  logic                      pclk_q;

  assign adapt = sh_out[ocs_pkg::BIT_ADAPT];

  function automatic logic [ocs_pkg::DIV_W-1:0] div_of(input ocs_pkg::ocs_src_t s,
                                                      input logic [15:0] c12, input logic [15:0] c3);
    case (s)
      ocs_pkg::SRC_ONE: div_of = c12[ocs_pkg::DIV1_LSB +: ocs_pkg::DIV_W];
      ocs_pkg::SRC_TWO: div_of = c12[ocs_pkg::DIV2_LSB +: ocs_pkg::DIV_W];
      default:          div_of = c3[ocs_pkg::DIV3_LSB +: ocs_pkg::DIV_W];
    endcase
  endfunction : div_of

  always_comb begin
    sel_d        = sel_q;
    frame_pend_d = frame_pend_q;
    if (tick) begin
      frame_pend_d = 1'b0;
      if (frame_pend_q || !adapt) begin
        sel_d = ocs_pkg::SRC_ONE;
      end else begin
        case (sel_q)
          ocs_pkg::SRC_ONE: begin
            if (fifo_level >= TH_HALF) begin
              sel_d = ocs_pkg::SRC_TWO;
            end
          end
          ocs_pkg::SRC_TWO: begin
            if (fifo_level >= TH_THREEQ) begin
              sel_d = ocs_pkg::SRC_THREE;
            end else if (fifo_level < TH_QUARTER) begin
              sel_d = ocs_pkg::SRC_ONE;
            end
          end
          default: begin
            if (fifo_level < TH_HALF) begin
              sel_d = ocs_pkg::SRC_TWO;
            end
          end
        endcase
      end
    end
    if (frame_start) begin
      frame_pend_d = 1'b1;
    end
    case (sel_q)
      ocs_pkg::SRC_ONE: slew_d = sh_c12[ocs_pkg::SLEW1_LSB +: ocs_pkg::SLEW_W];
      ocs_pkg::SRC_TWO: slew_d = sh_c12[ocs_pkg::SLEW2_LSB +: ocs_pkg::SLEW_W];
      default:          slew_d = sh_c3[ocs_pkg::SLEW3_LSB +: ocs_pkg::SLEW_W];
    endcase
    div_next = div_of(sel_d, sh_c12, sh_c3);
  end

  ocs_divider u_div (
    .clk    (clk),
    .resetn (resetn),
    .div    (div_next),
    .tick   (tick)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q        <= ocs_pkg::SRC_ONE;
      frame_pend_q <= 1'b0;
      slew_q       <= 3'h0;
      pclk_q       <= 1'b0;
    end else begin
      sel_q        <= sel_d;
      frame_pend_q <= frame_pend_d;
      slew_q       <= slew_d;
      pclk_q       <= tick;
    end
  end

  assign pixel_output_clock = pclk_q;
  assign clk_slew           = slew_q;
  assign clk_source         = sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // marker insertion

  ocs_pkg::ocs_fmt_t fmt_q;
  ocs_pkg::ocs_fmt_t fmt_d;
  logic [1:0]        idx_q;
  logic [1:0]        idx_d;
  logic              pre_done_q;
  logic              pre_done_d;
  logic              eof_pend_q;
  logic              eof_pend_d;
  logic [7:0]        odata_q;
  logic [7:0]        odata_d;
  logic              ovalid_q;
  logic              ovalid_d;
  logic              codes_on;
  logic              need_pre;
  logic [31:0]       code;

  assign codes_on = sh_out[ocs_pkg::BIT_SPOOF] && sh_out[ocs_pkg::BIT_CODES] && in_uncompressed;
  assign need_pre = codes_on && !pre_done_q && (in_frame_first || in_line_first);
  assign in_ready = tick && fmt_q == ocs_pkg::FMT_DATA && !need_pre;

  always_comb begin
    case (fmt_q)
      ocs_pkg::FMT_SOF: code = ocs_pkg::CODE_SOF;
      ocs_pkg::FMT_EOF: code = ocs_pkg::CODE_EOF;
      ocs_pkg::FMT_SOL: code = ocs_pkg::CODE_SOL;
      default:          code = ocs_pkg::CODE_EOL;
    endcase
  end

  always_comb begin
    fmt_d      = fmt_q;
    idx_d      = idx_q;
    pre_done_d = pre_done_q;
    eof_pend_d = eof_pend_q;
    odata_d    = odata_q;
    ovalid_d   = ovalid_q;
    if (tick) begin
      ovalid_d = 1'b0;
      case (fmt_q)
        ocs_pkg::FMT_DATA: begin
          if (in_valid && need_pre) begin
            fmt_d = (in_frame_first && codes_on) ? ocs_pkg::FMT_SOF : ocs_pkg::FMT_SOL;
            idx_d = 2'h0;
          end else if (in_valid) begin
            odata_d    = in_data;
            ovalid_d   = 1'b1;
            pre_done_d = 1'b0;
            if (codes_on && in_line_last) begin
              fmt_d      = ocs_pkg::FMT_EOL;
              idx_d      = 2'h0;
              eof_pend_d = in_frame_last;
            end
          end
        end
        default: begin
          odata_d  = ocs_pkg::marker_byte(code, idx_q);
          ovalid_d = 1'b1;
          idx_d    = idx_q + 2'h1;
          if (idx_q == ocs_pkg::IDX_LAST) begin
            idx_d = 2'h0;
            case (fmt_q)
              ocs_pkg::FMT_SOF: fmt_d = ocs_pkg::FMT_SOL;
              ocs_pkg::FMT_SOL: begin
                fmt_d      = ocs_pkg::FMT_DATA;
                pre_done_d = 1'b1;
              end
              ocs_pkg::FMT_EOL: fmt_d = eof_pend_q ? ocs_pkg::FMT_EOF : ocs_pkg::FMT_DATA;
              default:          fmt_d = ocs_pkg::FMT_DATA;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fmt_q      <= ocs_pkg::FMT_DATA;
      idx_q      <= 2'h0;
      pre_done_q <= 1'b0;
      eof_pend_q <= 1'b0;
      odata_q    <= 8'h00;
      ovalid_q   <= 1'b0;
    end else begin
      fmt_q      <= fmt_d;
      idx_q      <= idx_d;
      pre_done_q <= pre_done_d;
      eof_pend_q <= eof_pend_d;
      odata_q    <= odata_d;
      ovalid_q   <= ovalid_d;
    end
  end

  assign out_data  = odata_q;
  assign out_valid = ovalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_frame_marker_start: assert property (@(posedge clk) disable iff (!resetn)
    (fmt_q == ocs_pkg::FMT_DATA && tick && in_valid && in_frame_first && codes_on && !pre_done_q)
    |=> fmt_q == ocs_pkg::FMT_SOF) else $error("frame start marker not begun");
  a_sof_tail_byte: assert property (@(posedge clk) disable iff (!resetn)
    (fmt_q == ocs_pkg::FMT_SOF && tick && idx_q == ocs_pkg::IDX_LAST) |=> (out_valid && out_data == ocs_pkg::CODE_SOF[7:0]))
    else $error("wrong frame start tail byte");
  a_eol_tail_byte: assert property (@(posedge clk) disable iff (!resetn)
    (fmt_q == ocs_pkg::FMT_EOL && tick && idx_q == ocs_pkg::IDX_LAST) |=> (out_valid && out_data == ocs_pkg::CODE_EOL[7:0]))
    else $error("wrong line end tail byte");
  a_half_fill_move: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q == ocs_pkg::SRC_ONE && tick && adapt && !frame_pend_q && fifo_level >= TH_HALF)
    |=> sel_q == ocs_pkg::SRC_TWO) else $error("no move to source two");
  a_three_back_two: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q == ocs_pkg::SRC_THREE && tick && adapt && !frame_pend_q && fifo_level < TH_HALF)
    |=> sel_q == ocs_pkg::SRC_TWO) else $error("no return to source two");
  a_adapt_off_one: assert property (@(posedge clk) disable iff (!resetn)
    (!adapt && tick) |=> sel_q == ocs_pkg::SRC_ONE) else $error("source left one while not adaptive");
  a_frame_begins_one: assert property (@(posedge clk) disable iff (!resetn)
    (frame_pend_q && tick) |=> sel_q == ocs_pkg::SRC_ONE) else $error("frame not on source one");
  a_switch_period_end: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q != $past(sel_q)) |-> $past(tick)) else $error("source changed mid period");
  a_slew_two_used: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q == ocs_pkg::SRC_TWO) |=> clk_slew == $past(sh_c12[15:13])) else $error("wrong slew for source two");
  a_slew_one_used: assert property (@(posedge clk) disable iff (!resetn)
    (sel_q == ocs_pkg::SRC_ONE) |=> clk_slew == $past(sh_c12[7:5])) else $error("wrong slew for source one");

  c_frame_marker: cover property (@(posedge clk) disable iff (!resetn) fmt_q == ocs_pkg::FMT_EOF);
  c_third_source: cover property (@(posedge clk) disable iff (!resetn) sel_q == ocs_pkg::SRC_THREE);
  c_back_to_one:  cover property (@(posedge clk) disable iff (!resetn)
    sel_q == ocs_pkg::SRC_TWO ##1 sel_q == ocs_pkg::SRC_ONE);

endmodule : ocs_top
`default_nettype wire

//--- bench/ocs_host_capture.sv
// host capture model: takes output bytes and times the output clock
`timescale 1ns/10ps
`default_nettype none
module ocs_host_capture (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // pixel port
  input  wire logic       pixel_output_clock,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  // captured
  output logic            got,
  output logic [7:0]      byte_q,
  output logic [7:0]      period_q
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      got      <= 1'b0;
      byte_q   <= 8'h00;
      period_q <= 8'h00;
      cnt_q    <= 8'h00;
    end else begin
      got   <= pixel_output_clock & out_valid;
      cnt_q <= pixel_output_clock ? 8'h00 : cnt_q + 8'h01;
      if (pixel_output_clock) begin
        period_q <= cnt_q + 8'h01;
        byte_q   <= out_valid ? out_data : byte_q;
      end
    end
  end
endmodule : ocs_host_capture
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the output clock and shadow block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, resetn, reg_wr, reg_rd, vblank_end, frame_start, in_valid, in_unc;
  logic        f_ff, f_lf, f_ll, f_fl, in_ready, poc, out_valid, got, rd_seen;
  logic [7:0]  reg_addr, in_data, out_data, byte_q, period_q;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0]  fifo_level;
  logic [2:0]  clk_slew;
  logic [1:0]  clk_source;
  logic [31:0] rq[$];
  logic [7:0]  sq[$];
  int          num_errors, compares, cycles;
  logic [3:0]  d, eff;
  logic [7:0]  b[4];
  ocs_top #(.FIFO_DEPTH(16)) i_ocs_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vblank_end(vblank_end), .frame_start(frame_start), .fifo_level(fifo_level), .in_valid(in_valid),
    .in_data(in_data), .in_uncompressed(in_unc), .in_frame_first(f_ff), .in_line_first(f_lf),
    .in_line_last(f_ll), .in_frame_last(f_fl), .in_ready(in_ready), .pixel_output_clock(poc),
    .out_data(out_data), .out_valid(out_valid), .clk_slew(clk_slew), .clk_source(clk_source));
  ocs_host_capture i_ocs_host_capture (.clk(clk), .resetn(resetn), .pixel_output_clock(poc),
    .out_valid(out_valid), .out_data(out_data), .got(got), .byte_q(byte_q), .period_q(period_q));
  ////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic strobe(input bit vb);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (vb) vblank_end <= 1'b1;
    else frame_start <= 1'b1;
    @(posedge clk);
    vblank_end  <= 1'b0;
    frame_start <= 1'b0;
    @(posedge clk);
  endtask : strobe
  task automatic wait_src(input logic [1:0] e);
    int k;
    k = 0;
    while (k < 60 && clk_source !== e) begin
      @(posedge clk);
      k++;
    end
    check(clk_source, e);
  endtask : wait_src
  task automatic code(input logic [31:0] c);
    for (int j = 3; j >= 0; j--) sq.push_back(c[8*j +: 8]);
  endtask : code
  task automatic send(input logic [7:0] v, input logic [3:0] fl);
    int k;
    in_valid <= 1'b1;
    in_data  <= v;
    {f_ff, f_lf, f_ll, f_fl} <= fl;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (in_ready !== 1'b1 && k < 100);
  endtask : send
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (rd_seen === 1'b1) check(reg_rdata, rq.pop_front());
    rd_seen <= reg_rd;
    if (got === 1'b1) begin
      if (sq.size() == 0) check(byte_q, 8'hxx);
      else check(byte_q, sq.pop_front());
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, vblank_end, frame_start, in_valid, f_ff, f_lf, f_ll, f_fl} = '0;
    {reg_addr, reg_wdata, in_data, fifo_level} = '0;
    in_unc = 1'b1;
    void'($urandom(32'h73360cfe));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'h0d, 16'h0007);
    rd(8'h0e, 16'h0501);
    rd(8'h0f, 16'h0003);
    rd(8'h40, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h0e, 16'hffff);
    rd(8'h0e, 16'hefef);
    for (int i = 0; i < 4; i++) begin
      d = (i == 3) ? 4'(4'h5 + $urandom % 11) : 4'(i * i);
      eff = (d == 4'h0) ? 4'h1 : d;
      wr(8'h0e, {12'h050, d});
      strobe(1'b1);
      cyc(40);
      check(period_q, eff);
    end
    wr(8'h0d, 16'h0807);
    rd(8'h20, 16'h0004);
    wr(8'h0e, 16'h0504);
    cyc(40);
    check(period_q, eff);
    strobe(1'b1);
    cyc(40);
    check(period_q, eff);
    wr(8'h0d, 16'h0007);
    strobe(1'b1);
    cyc(40);
    check(period_q, 4);
    wr(8'h0e, 16'ha261);
    fifo_level <= 5'd8;
    strobe(1'b1);
    cyc(20);
    check(clk_source, 0);
    check(clk_slew, 3);
    wr(8'h0d, 16'h0047);
    strobe(1'b1);
    wait_src(2'd1);
    cyc(20);
    check(clk_slew, 5);
    check(period_q, 2);
    fifo_level <= 5'd12;
    wait_src(2'd2);
    fifo_level <= 5'd6;
    wait_src(2'd1);
    strobe(1'b0);
    wait_src(2'd0);
    cyc(10);
    check(clk_source, 0);
    fifo_level <= 5'd8;
    wait_src(2'd1);
    fifo_level <= 5'd2;
    wait_src(2'd0);
    fifo_level <= 5'd0;
    wr(8'h0e, 16'h0501);
    for (int m = 0; m < 2; m++) begin
      wr(8'h0d, m ? 16'h0407 : 16'h0007);
      strobe(1'b1);
      cyc(4);
      foreach (b[j]) b[j] = 8'($urandom);
      if (m) code(32'hff0000ab);
      if (m) code(32'hff0000b0);
      sq.push_back(b[0]);
      sq.push_back(b[1]);
      if (m) code(32'hff0000bd);
      if (m) code(32'hff0000b0);
      sq.push_back(b[2]);
      sq.push_back(b[3]);
      if (m) code(32'hff0000bd);
      if (m) code(32'hff0000b6);
      send(b[0], 4'b1100);
      send(b[1], 4'b0010);
      send(b[2], 4'b0100);
      send(b[3], 4'b0011);
      in_valid <= 1'b0;
      cyc(40);
      check(sq.size(), 0);
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
